// File: verilog/rst_init_pkg.sv
// constants and carrier types for the reset sequencing block
package rst_init_pkg;
  // oscillator source codes
  typedef enum logic [1:0] {
    osc_fast_rc,
    osc_fast_xtal,
    osc_slow_xtal,
    osc_slow_rc
  } osc_src_e;

  // settle counts at 10 MHz are in system clock cycles, so taken as printed
  localparam logic [10:0] settle_fast_cycles = 11'd16;
  localparam logic [10:0] settle_slow_xtal_cycles = 11'd1024;
  localparam logic [10:0] settle_slow_rc_cycles = 11'd2;

  // reset values
  localparam logic [7:0] pc_low_rst = 8'h00;
  localparam logic [7:0] port_rst = 8'hff;
  localparam logic [7:0] pullup_rst = 8'h00;
  localparam logic [7:0] intc_rst = 8'h00;
  localparam logic [7:0] tmr_ctl_rst = 8'h00;
  localparam logic [9:0] analog_sel_rst = 10'h3ff;
  localparam logic [4:0] stack_top = 5'h00;
  localparam logic [7:0] wdt_clear = 8'h00;

  // register offsets
  localparam logic [3:0] reg_status = 4'h0;
  localparam logic [3:0] reg_ctrl = 4'h1;
  localparam logic [3:0] reg_irq_stat = 4'h2;
  localparam logic [3:0] reg_irq_mask = 4'h3;
  localparam logic [3:0] reg_osc = 4'h4;
  localparam logic [3:0] reg_port_data = 4'h5;
  localparam logic [3:0] reg_port_dir = 4'h6;
  localparam logic [3:0] reg_intc = 4'h7;
  localparam logic [3:0] reg_tmr = 4'h8;

  // field positions
  localparam int status_pwrdn_bit = 4;
  localparam int status_to_bit = 5;
  localparam int ctrl_sdrf_bit = 2;
  localparam int ev_por_bit = 0;
  localparam int ev_sdr_bit = 1;
  localparam int ev_wdt_bit = 2;
  localparam int ev_wdt_sleep_bit = 3;

  // reset request group from the watchdog and supply monitor
  typedef struct packed {
    logic por;
    logic supply_drop;
    logic wdt_timeout;
    logic in_sleep;
  } rst_req_s;
endpackage : rst_init_pkg

// File: verilog/reset_initial_conditions.sv
// reset cause tracking, per-source initial values and wake settle timing
// How it works
// - sleep watchdog reset clears pc, sp only
// - fast oscillators settle sixteen cycles before resuming
// - slow crystal settles 1024 cycles
// - slow rc settles two cycles
// - power-on clears timeout and powerdown flags
// - supply drop keeps both flags
// - normal watchdog reset sets timeout flag only
// - sleep watchdog reset sets both flags
// - power-on disables all interrupts
// - power-on clears watchdog, which then counts
// - power-on switches timers off
// - power-on makes ports inputs, analog pins converter
// - power-on zeroes pc, stack at top
// - each reset loads its defined register values
// - normal watchdog reset equals supply drop plus flag
// - supply drop sets sticky flag, software clears
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module reset_initial_conditions (
  input wire logic sys_clk, // system clock, 10 MHz
  input wire logic srst, // synchronous reset, active high (power-on)
  input wire rst_init_pkg::rst_req_s req, // reset requests, one-cycle pulses; in_sleep is a level
  input wire logic [3:0] addr, // register address
  input wire logic [7:0] wdata, // register write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [7:0] rdata, // read data, cycle after read strobe
  output logic irq, // level interrupt
  output logic cpu_hold, // core held while settling
  output logic [7:0] pc_low_byte, // program counter low byte
  output logic [4:0] stack_ptr, // stack pointer
  output logic [7:0] port_data, // port data register
  output logic [7:0] port_dir, // port direction, 1 = input
  output logic [9:0] analog_sel, // analog input pin select
  output logic [7:0] intc, // interrupt enables
  output logic [7:0] tmr_ctl, // timer control, 0 = off
  output logic [7:0] watchdog_timer, // watchdog count
  output logic watchdog_timeout_flag, // timeout flag
  output logic powerdown_flag, // power-down flag
  output logic supply_drop_reset_flag // sticky supply drop flag
);
  import rst_init_pkg::*;

  // ---------------------------------------------------------------
  // reset event decode
  // ---------------------------------------------------------------
  logic ev_sleep_wdt, ev_full_rst, ev_wdt_norm, ev_sdr;
  // a supply drop while asleep cannot happen: the monitor is off then
  assign ev_sdr = req.supply_drop & ~req.in_sleep;
  assign ev_wdt_norm = req.wdt_timeout & ~req.in_sleep & ~ev_sdr;
  assign ev_sleep_wdt = req.wdt_timeout & req.in_sleep & ~req.supply_drop;
  assign ev_full_rst = ev_sdr | ev_wdt_norm;

  // ---------------------------------------------------------------
  // settle timer
  // ---------------------------------------------------------------
  typedef enum logic {st_run, st_settle} seq_e;
  seq_e state_q, state_d;
  logic [10:0] cnt_q, cnt_d;
  osc_src_e osc_q, osc_d;

  function automatic logic [10:0] settle_len(input osc_src_e s);
    unique case (s)
      osc_fast_rc, osc_fast_xtal: settle_len = settle_fast_cycles;
      osc_slow_xtal: settle_len = settle_slow_xtal_cycles;
      osc_slow_rc: settle_len = settle_slow_rc_cycles;
    endcase
  endfunction : settle_len

  // every reset except power-on restarts the settle wait; core held until it expires
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (ev_sleep_wdt || ev_full_rst) begin
      state_d = st_settle;
      cnt_d = settle_len(osc_q) - 11'd1;
    end else if (state_q == st_settle) begin
      if (cnt_q == 11'd0) begin
        state_d = st_run;
      end else begin
        cnt_d = cnt_q - 11'd1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= st_run;
      cnt_q <= 11'd0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign cpu_hold = (state_q == st_settle);

  // ---------------------------------------------------------------
  // core state registers and flags
  // ---------------------------------------------------------------
  logic [7:0] pc_d, pd_d, pdir_d, intc_d, tmr_d, wdt_d;
  logic [4:0] sp_d;
  logic [9:0] an_d;
  logic to_d, pwrdn_d, sdrf_d;
  logic [3:0] ist_q, ist_d, imsk_q, imsk_d;
  logic wr_status, wr_ctrl;
  assign wr_status = wr_en && addr == reg_status;
  assign wr_ctrl = wr_en && addr == reg_ctrl;

  // per-source effects; reset values override software writes to the same register in the same cycle
  always_comb begin
    pc_d = pc_low_byte;
    sp_d = stack_ptr;
    pd_d = port_data;
    pdir_d = port_dir;
    an_d = analog_sel;
    intc_d = intc;
    tmr_d = tmr_ctl;
    wdt_d = cpu_hold ? watchdog_timer : watchdog_timer + 8'h01;
    to_d = watchdog_timeout_flag;
    pwrdn_d = powerdown_flag;
    sdrf_d = supply_drop_reset_flag;
    osc_d = osc_q;
    if (wr_status) begin
      to_d = wdata[status_to_bit];
      pwrdn_d = wdata[status_pwrdn_bit];
    end
    if (wr_ctrl && !wdata[ctrl_sdrf_bit]) begin
      sdrf_d = 1'b0;
    end
    if (wr_en && addr == reg_osc) osc_d = osc_src_e'(wdata[1:0]);
    if (wr_en && addr == reg_port_data) pd_d = wdata;
    if (wr_en && addr == reg_port_dir) pdir_d = wdata;
    if (wr_en && addr == reg_intc) intc_d = wdata;
    if (wr_en && addr == reg_tmr) tmr_d = wdata;
    if (ev_sleep_wdt) begin
      pc_d = pc_low_rst;
      sp_d = stack_top;
      to_d = 1'b1;
      pwrdn_d = 1'b1;
    end
    if (ev_full_rst) begin
      pc_d = pc_low_rst;
      sp_d = stack_top;
      pd_d = port_rst;
      pdir_d = port_rst;
      an_d = analog_sel_rst;
      intc_d = intc_rst;
      tmr_d = tmr_ctl_rst;
      wdt_d = wdt_clear;
      // supply drop keeps flags; watchdog adds the timeout flag
      to_d = ev_wdt_norm ? 1'b1 : watchdog_timeout_flag;
      pwrdn_d = powerdown_flag;
    end
    if (ev_sdr) sdrf_d = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pc_low_byte <= pc_low_rst;
      stack_ptr <= stack_top;
      port_data <= port_rst;
      port_dir <= port_rst;
      analog_sel <= analog_sel_rst;
      intc <= intc_rst;
      tmr_ctl <= tmr_ctl_rst;
      watchdog_timer <= wdt_clear;
      watchdog_timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
      supply_drop_reset_flag <= 1'b0;
      osc_q <= osc_fast_rc;
    end else begin
      pc_low_byte <= pc_d;
      stack_ptr <= sp_d;
      port_data <= pd_d;
      port_dir <= pdir_d;
      analog_sel <= an_d;
      intc <= intc_d;
      tmr_ctl <= tmr_d;
      watchdog_timer <= wdt_d;
      watchdog_timeout_flag <= to_d;
      powerdown_flag <= pwrdn_d;
      supply_drop_reset_flag <= sdrf_d;
      osc_q <= osc_d;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, mask and read port
  // ---------------------------------------------------------------
  logic [3:0] ev_vec;
  logic [7:0] rdata_d;
  assign ev_vec = {ev_sleep_wdt, ev_wdt_norm, ev_sdr, 1'b0};

  // set wins over a write-one clear in the same cycle
  always_comb begin
    ist_d = ist_q;
    imsk_d = imsk_q;
    if (wr_en && addr == reg_irq_stat) ist_d = ist_q & ~wdata[3:0];
    if (wr_en && addr == reg_irq_mask) imsk_d = wdata[3:0];
    ist_d = ist_d | ev_vec;
    rdata_d = 8'h00;
    if (rd_en) begin
      unique case (addr)
        reg_status: rdata_d = {2'b00, watchdog_timeout_flag, powerdown_flag, 4'h0};
        reg_ctrl: rdata_d = {5'h00, supply_drop_reset_flag, 2'b00};
        reg_irq_stat: rdata_d = {4'h0, ist_q};
        reg_irq_mask: rdata_d = {4'h0, imsk_q};
        reg_osc: rdata_d = {6'h00, osc_q};
        reg_port_data: rdata_d = port_data;
        reg_port_dir: rdata_d = port_dir;
        reg_intc: rdata_d = intc;
        reg_tmr: rdata_d = tmr_ctl;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ist_q <= 4'h1; // power-on event recorded
      imsk_q <= 4'h0;
      rdata <= 8'h00;
    end else begin
      ist_q <= ist_d;
      imsk_q <= imsk_d;
      rdata <= rdata_d;
    end
  end

  assign irq = |(ist_q & imsk_q);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence sleep_wdt_s;
    ev_sleep_wdt;
  endsequence

  sleep_wdt_flags_a: assert property (@(posedge sys_clk) disable iff (srst)
    sleep_wdt_s |=> watchdog_timeout_flag && powerdown_flag)
    else $error("sleep watchdog reset flags wrong");
  sleep_wdt_keep_a: assert property (@(posedge sys_clk) disable iff (srst)
    sleep_wdt_s |=> pc_low_byte == 8'h00 && stack_ptr == 5'h00 && port_dir == $past(port_dir))
    else $error("sleep watchdog reset touched other state");
  // settle length is pinned by its start value, unit steps and the drop at zero
  sequence wake_fast_s;
    (ev_sleep_wdt || ev_full_rst) && osc_q inside {osc_fast_rc, osc_fast_xtal};
  endsequence

  sequence fast_hold_s;
    (cpu_hold && cnt_q == 11'h00f) ##15 (cpu_hold && cnt_q == 11'h000) ##1 !cpu_hold;
  endsequence

  fast_settle_a: assert property (@(posedge sys_clk) disable iff (srst)
    wake_fast_s |=> fast_hold_s)
    else $error("fast settle length wrong");
  slow_rc_settle_a: assert property (@(posedge sys_clk) disable iff (srst)
    (ev_sleep_wdt && osc_q == osc_slow_rc) |=> cpu_hold [*2] ##1 !cpu_hold)
    else $error("slow rc settle length wrong");
  xtal_settle_a: assert property (@(posedge sys_clk) disable iff (srst)
    ((ev_sleep_wdt || ev_full_rst) && osc_q == osc_slow_xtal) |=> cnt_q == 11'd1023 && cpu_hold)
    else $error("slow crystal settle count wrong");
  sdr_flags_a: assert property (@(posedge sys_clk) disable iff (srst)
    ev_sdr |=> watchdog_timeout_flag == $past(watchdog_timeout_flag) && powerdown_flag == $past(powerdown_flag))
    else $error("supply drop changed flags");
  wdt_norm_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
    ev_wdt_norm |=> watchdog_timeout_flag && powerdown_flag == $past(powerdown_flag))
    else $error("watchdog reset flags wrong");
  full_rst_regs_a: assert property (@(posedge sys_clk) disable iff (srst)
    ev_full_rst |=> port_data == 8'hff && port_dir == 8'hff && pc_low_byte == 8'h00 && intc == 8'h00)
    else $error("register reset values wrong");
  sdr_sticky_a: assert property (@(posedge sys_clk) disable iff (srst)
    ev_sdr |=> supply_drop_reset_flag)
    else $error("supply drop flag not set");
  por_flags_a: assert property (@(posedge sys_clk)
    $fell(srst) |-> !watchdog_timeout_flag && !powerdown_flag && intc == 8'h00 && tmr_ctl == 8'h00)
    else $error("power-on state wrong");
  // a skipped count would shorten the wait, so every held cycle with a count above zero and no new reset must step by one
  cnt_step_a: assert property (@(posedge sys_clk) disable iff (srst)
    (cpu_hold && cnt_q != 11'h000 && !ev_sleep_wdt && !ev_full_rst) |=> cpu_hold && cnt_q == $past(cnt_q) - 11'h001)
    else $error("settle count did not step");
  settle_end_a: assert property (@(posedge sys_clk) disable iff (srst)
    (cpu_hold && cnt_q == 11'h000 && !ev_sleep_wdt && !ev_full_rst) |=> !cpu_hold)
    else $error("core still held after settle");
  por_regs_a: assert property (@(posedge sys_clk)
    $fell(srst) |-> port_dir == port_rst && analog_sel == analog_sel_rst && pc_low_byte == pc_low_rst)
    else $error("power-on port state wrong");
  wdt_count_a: assert property (@(posedge sys_clk) disable iff (srst)
    (!srst && !cpu_hold && !ev_full_rst) |=> watchdog_timer == $past(watchdog_timer) + 8'h01)
    else $error("watchdog did not count");
  // frozen while held so a long crystal settle cannot run the count out
  wdt_freeze_a: assert property (@(posedge sys_clk) disable iff (srst)
    (cpu_hold && !ev_full_rst) |=> watchdog_timer == $past(watchdog_timer))
    else $error("watchdog moved while held");
  sdr_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
    (wr_ctrl && !wdata[ctrl_sdrf_bit] && !ev_sdr) |=> !supply_drop_reset_flag)
    else $error("supply drop flag not cleared");
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
    !rd_en |=> rdata == 8'h00)
    else $error("read data not idle");
endmodule : reset_initial_conditions

// File: verif/reset_initial_conditions_tb.sv
// self-checking bench for the reset sequencing block
`timescale 1ns/1ns
module reset_initial_conditions_tb;
  import rst_init_pkg::*;
  logic sys_clk, srst, wr_en, rd_en, irq, cpu_hold;
  logic watchdog_timeout_flag, powerdown_flag, supply_drop_reset_flag;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, pc_low_byte, port_data, port_dir, intc, tmr_ctl, watchdog_timer, rv;
  logic [4:0] stack_ptr;
  logic [9:0] analog_sel;
  rst_req_s req;
  int n_mismatch = 0;
  int samples_checked = 0;
  // settle bounds per oscillator code, in cycles
  int lo_tab[4] = '{15, 15, 1024, 1};
  int hi_tab[4] = '{16, 16, 1024, 2};

  reset_initial_conditions dut (.sys_clk, .srst, .req, .addr, .wdata, .wr_en, .rd_en, .rdata, .irq,
    .cpu_hold, .pc_low_byte, .stack_ptr, .port_data, .port_dir, .analog_sel, .intc, .tmr_ctl,
    .watchdog_timer, .watchdog_timeout_flag, .powerdown_flag, .supply_drop_reset_flag);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // strobes drop at the next edge, so a following task never re-raises in the same step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rdata; // only valid in this one cycle
  endtask : rd

  // in_sleep is a level and is left as given
  task automatic pulse(input logic wdt, input logic sd, input logic slp);
    @(posedge sys_clk);
    req.wdt_timeout <= wdt;
    req.supply_drop <= sd;
    req.in_sleep <= slp;
    @(posedge sys_clk);
    req.wdt_timeout <= 1'b0;
    req.supply_drop <= 1'b0;
    #1;
  endtask : pulse

  // bounded so a stuck hold cannot hang the run
  task automatic hold_len(output int n);
    n = 0;
    while (cpu_hold === 1'b1 && n < 2000) begin
      n++;
      @(posedge sys_clk);
      #1;
    end
  endtask : hold_len

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_por;
    #1;
    chk("wdt_clear", watchdog_timer, 8'h00);
    @(posedge sys_clk);
    #1;
    chk("wdt_count", watchdog_timer, 8'h01);
    chk("flags", {watchdog_timeout_flag, powerdown_flag}, 2'b00);
    chk("intc", intc, 8'h00);
    chk("tmr", tmr_ctl, 8'h00);
    chk("ports", {port_data, port_dir}, 16'hffff);
    chk("analog", analog_sel, 10'h3ff);
    chk("pc_sp", {pc_low_byte, stack_ptr}, {8'h00, stack_top});
    rd(reg_irq_stat, rv);
    chk("por_stat", rv, 8'h01);
    rd(4'hf, rv);
    chk("unmapped", rv, 8'h00);
    wr(reg_irq_mask, 8'h01);
    chk("irq_on", irq, 1'b1);
    wr(reg_irq_stat, 8'h01);
    chk("irq_w1c", irq, 1'b0);
  endtask : t_por

  task automatic t_supply;
    int n;
    wr(reg_status, 8'h20);
    wr(reg_port_data, 8'h00);
    wr(reg_irq_mask, 8'h02);
    pulse(1'b0, 1'b1, 1'b0);
    chk("sd_flags", {watchdog_timeout_flag, powerdown_flag}, 2'b10);
    chk("sd_port", port_data, 8'hff);
    chk("sd_flag", supply_drop_reset_flag, 1'b1);
    chk("sd_irq", irq, 1'b1);
    hold_len(n);
    chk("sd_settle", (n >= lo_tab[0] && n <= hi_tab[0]), 1'b1);
    rd(reg_ctrl, rv);
    chk("ctrl_rd", rv[ctrl_sdrf_bit], 1'b1);
    wr(reg_ctrl, 8'h00);
    chk("sd_clear", supply_drop_reset_flag, 1'b0);
    wr(reg_irq_stat, 8'h02);
    chk("sd_irq_clr", irq, 1'b0);
  endtask : t_supply

  task automatic t_wdt_norm;
    int n;
    wr(reg_status, 8'h10);
    wr(reg_port_dir, 8'h0f);
    pulse(1'b1, 1'b0, 1'b0);
    chk("wn_flags", {watchdog_timeout_flag, powerdown_flag}, 2'b11);
    chk("wn_dir", port_dir, 8'hff);
    chk("wn_pc", pc_low_byte, 8'h00);
    hold_len(n);
    chk("wn_settle", (n >= lo_tab[0] && n <= hi_tab[0]), 1'b1);
    rd(reg_status, rv);
    chk("wn_status", rv, 8'h30);
  endtask : t_wdt_norm

  // each oscillator code in turn, sleep watchdog wake-up
  task automatic t_sleep;
    int n;
    for (int i = 0; i < 4; i++) begin
      wr(reg_status, 8'h00);
      wr(reg_port_data, 8'h5a);
      wr(reg_intc, 8'h3c);
      wr(reg_osc, 8'(i));
      pulse(1'b1, 1'b0, 1'b1);
      chk("ws_flags", {watchdog_timeout_flag, powerdown_flag}, 2'b11);
      chk("ws_keep", {port_data, intc}, 16'h5a3c);
      chk("ws_pc_sp", {pc_low_byte, stack_ptr}, 13'h0000);
      hold_len(n);
      chk("settle", (n >= lo_tab[i] && n <= hi_tab[i]), 1'b1);
    end
  endtask : t_sleep

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    req = '0;
    addr = 4'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    t_por();
    t_supply();
    t_wdt_norm();
    t_sleep();
    tally_and_finish();
  end

  // whole run is near 1170 cycles; cut off well past that
  initial begin
    #2000000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : reset_initial_conditions_tb
